/* pkg/bbpd_pkg.sv */
package bbpd_pkg;

    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int BBPD_DATA_W = 16;
    localparam int BBPD_FIFO_DEPTH = 16;
    localparam int BBPD_CODE_W = 4;

    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int BBPD_FUNC_LSB = 12;
    localparam int BBPD_SHIFT_LSB = 8;
    localparam int BBPD_LEFT_LSB = 4;
    localparam int BBPD_RIGHT_LSB = 0;
    localparam logic [15:0] BBPD_CTRL_RESET = 16'h0000;

    typedef struct packed {
        logic [3:0] function_select_field;
        logic [3:0] shift_count_field;
        logic [3:0] left_edge_code;
        logic [3:0] right_edge_code;
    } bbpd_ctrl_t;

    // ------------------------------------------------------------
    // selections and reset values
    // ------------------------------------------------------------
    localparam logic BBPD_OUT_RESULT = 1'b0;
    localparam logic BBPD_OUT_FIFO = 1'b1;
    localparam logic BBPD_FIFO_IN_SHIFT = 1'b0;
    localparam logic BBPD_FIFO_IN_RESULT = 1'b1;
    localparam logic [15:0] BBPD_WORD_RESET = 16'h0000;
    localparam logic [15:0] BBPD_ALL_ONES = 16'hFFFF;

    // operands and products of the logic unit
    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
    } bbpd_operands_t;

    typedef struct packed {
        logic [15:0] result;
        logic [15:0] mask;
    } bbpd_lu_out_t;

endpackage

/* verification/bbpd_bus_partner.sv */
`timescale 1ns/10ps
module bbpd_bus_partner (
    input wire logic clock,
    input wire logic [15:0] dev_data,
    input wire logic dev_oe_b,
    input wire logic [15:0] word,
    input wire logic drv,
    output logic [15:0] bus
);
    logic [15:0] last_reg = 16'h0000;

    // released bus flips to the inverse of its last clocked value each cycle, so stale data returns every other cycle
    always_comb begin
        if (!dev_oe_b) begin
            bus = dev_data;
        end else if (drv) begin
            bus = word;
        end else begin
            bus = ~last_reg;
        end
    end

    always_ff @(posedge clock) begin
        last_reg <= bus;
    end
endmodule

/* verification/bitblt_pixel_datapath_bench.sv */
`timescale 1ns/10ps
module bitblt_pixel_datapath_bench
    import bbpd_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] data_in, data_out, a, b, d, c, e, m;
    logic [15:0] word = 16'h0000;
    logic [15:0] ctl = BBPD_CTRL_RESET;
    logic data_oe_b, pixel_out, pixel_oe_b, fifo_full, fifo_empty, pixel_in;
    logic control_load_strobe = 1'b0, source_strobe = 1'b0, dest_strobe = 1'b0;
    logic fifo_write = 1'b0, fifo_read = 1'b0, data_drive = 1'b0, drv = 1'b0;
    logic pixel_drive = 1'b0, pixel_load = 1'b0, pix_drv = 1'b0;
    logic line_mode = 1'b0, barrel_swap = 1'b0, out_select = 1'b0;
    logic fifo_in_select = BBPD_FIFO_IN_SHIFT;
    logic [3:0] pixel_bit_select = 4'h0;
    logic [15:0] q[$];
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;

    assign pixel_in = pixel_oe_b ? pix_drv : pixel_out;

    bbpd_top #(.FIFO_DEPTH(BBPD_FIFO_DEPTH)) bbpd_top_inst (
        .clock(clock), .rst_b(rst_b), .data_in(data_in), .data_out(data_out),
        .data_oe_b(data_oe_b), .control_load_strobe(control_load_strobe),
        .source_strobe(source_strobe), .dest_strobe(dest_strobe), .line_mode(line_mode),
        .barrel_swap(barrel_swap), .fifo_write(fifo_write),
        .fifo_in_select(fifo_in_select), .fifo_read(fifo_read),
        .data_drive(data_drive), .out_select(out_select), .pixel_in(pixel_in),
        .pixel_load(pixel_load), .pixel_drive(pixel_drive),
        .pixel_bit_select(pixel_bit_select), .pixel_out(pixel_out),
        .pixel_oe_b(pixel_oe_b), .fifo_full(fifo_full), .fifo_empty(fifo_empty)
    );

    bbpd_bus_partner bbpd_bus_partner_inst (
        .clock(clock), .dev_data(data_out), .dev_oe_b(data_oe_b),
        .word(word), .drv(drv), .bus(data_in)
    );

    initial begin
        forever #2.5 clock = ~clock;
    end

    // ----------------------------------------
    // reference model
    // ----------------------------------------
    function automatic logic [15:0] lu(input logic [3:0] f, input logic [15:0] s, dd);
        case (f)
            4'h0: lu = 16'h0000;
            4'h1: lu = ~s & ~dd;
            4'h2: lu = ~s & dd;
            4'h3: lu = ~s;
            4'h4: lu = s & ~dd;
            4'h5: lu = ~dd;
            4'h6: lu = s ^ dd;
            4'h7: lu = ~s | ~dd;
            4'h8: lu = s & dd;
            4'h9: lu = ~(s ^ dd);
            4'hA: lu = dd;
            4'hB: lu = ~s | dd;
            4'hC: lu = s;
            4'hD: lu = s | ~dd;
            4'hE: lu = s | dd;
            default: lu = 16'hFFFF;
        endcase
    endfunction

    function automatic logic [15:0] shf(input logic [15:0] x, y, input logic [3:0] i);
        logic [31:0] t;
        t = {x, y} << i;
        return t[31:16];
    endfunction

    function automatic logic [15:0] msk(input logic [15:0] w);
        msk = (16'hFFFF >> w[7:4]) & (16'hFFFF << (4'hF - w[3:0]));
    endfunction

    // ----------------------------------------
    // drivers and checks
    // ----------------------------------------
    task automatic step;
        @(posedge clock);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one assignment of every strobe per step avoids same-step races
    task automatic go(input logic [8:0] v);
        {control_load_strobe, source_strobe, dest_strobe, drv} = v[8:5];
        {fifo_write, fifo_read, data_drive, pixel_drive, pixel_load} = v[4:0];
        step;
    endtask

    task automatic idle(input int n);
        repeat (n) go(9'h000);
    endtask

    task automatic put(input logic [15:0] w, input logic [2:0] k);
        word = w;
        if (k == 3'b100) ctl = w;
        go({k, 6'h20});
    endtask

    task automatic outchk(input logic [15:0] exp, input logic [8:0] v);
        pixel_bit_select = 4'($urandom);
        go(v);
        chk("data_out", data_out, exp);
        chk("data_oe_b", 16'(data_oe_b), 16'h0000);
        chk("pixel_oe_b", 16'(pixel_oe_b), 16'h0000);
        chk("pixel_out", 16'(pixel_out), 16'(exp[pixel_bit_select]));
        go(9'h000);
        chk("data_oe_b", 16'(data_oe_b), 16'h0001);
        chk("pixel_oe_b", 16'(pixel_oe_b), 16'h0001);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            finish_test;
        end
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'h7B4105BE));
        repeat (5) @(posedge clock);
        #1 rst_b = 1'b1;
        chk("data_oe_b", 16'(data_oe_b), 16'h0001);
        chk("fifo_empty", 16'(fifo_empty), 16'h0001);
        // control reloaded every other word, so odd words run on held settings
        for (int i = 0; i < 32; i++) begin
            if (i % 2 == 0) begin
                c = 16'($urandom);
                c[15:12] = 4'(i / 2);
                if (i == 0) c[11:8] = 4'h0;
                put(c, 3'b100);
            end
            a = 16'($urandom);
            b = 16'($urandom);
            d = 16'($urandom);
            barrel_swap = 1'($urandom);
            put(a, 3'b010);
            put(b, 3'b010);
            idle(3);
            go(9'h010);
            q.push_back(barrel_swap ? shf(b, a, ctl[11:8]) : shf(a, b, ctl[11:8]));
            put(d, 3'b001);
            idle(2);
            e = q.pop_front();
            m = msk(ctl);
            outchk((lu(ctl[15:12], e, d) & m) | (d & ~m), 9'h00E);
        end
        $display("block transfer test done");
        line_mode = 1'b1;
        for (int i = 0; i < 8; i++) begin
            pix_drv = 1'($urandom);
            go(9'h001);
            // functions 8 to 15 so the pass-source and all-ones cases are reached
            put({4'(i + 8), 12'($urandom)}, 3'b100);
            d = 16'($urandom);
            put(d, 3'b001);
            idle(2);
            outchk(lu(ctl[15:12], {16{pix_drv}}, d), 9'h006);
        end
        $display("line mode test done");
        line_mode = 1'b0;
        put(16'h5A3C, 3'b010);
        put(16'hC3A5, 3'b010);
        idle(3);
        repeat (17) go(9'h010);
        chk("fifo_full", 16'(fifo_full), 16'h0001);
        out_select = 1'b1;
        e = barrel_swap ? shf(16'hC3A5, 16'h5A3C, ctl[11:8]) : shf(16'h5A3C, 16'hC3A5, ctl[11:8]);
        repeat (16) begin
            go(9'h00C);
            chk("data_out", data_out, e);
        end
        go(9'h000);
        chk("fifo_empty", 16'(fifo_empty), 16'h0001);
        // store a line-mode result in the fifo, then read it back out
        fifo_in_select = BBPD_FIFO_IN_RESULT;
        line_mode = 1'b1;
        go(9'h010);
        go(9'h00C);
        chk("data_out", data_out, lu(ctl[15:12], {16{pix_drv}}, d));
        $display("fifo test done");
        finish_test;
    end
endmodule

/* verilog/bbpd_logic_unit.sv */
`timescale 1ns/10ps
module bbpd_logic_unit
    import bbpd_pkg::*;
(
    input wire bbpd_ctrl_t ctrl,
    input wire logic line_mode,
    input wire bbpd_operands_t ops,
    output bbpd_lu_out_t lu_out
);

    // ------------------------------------------------------------
    // per-bit boolean function
    // ------------------------------------------------------------
    function automatic logic [15:0] bbpd_func(input logic [3:0] f, input logic [15:0] s,
                                              input logic [15:0] d);
        case (f)
            4'h0: bbpd_func = 16'h0000;
            4'h1: bbpd_func = ~s & ~d;
            4'h2: bbpd_func = ~s & d;
            4'h3: bbpd_func = ~s;
            4'h4: bbpd_func = s & ~d;
            4'h5: bbpd_func = ~d;
            4'h6: bbpd_func = s ^ d;
            4'h7: bbpd_func = ~s | ~d;
            4'h8: bbpd_func = s & d;
            4'h9: bbpd_func = ~(s ^ d);
            4'hA: bbpd_func = d;
            4'hB: bbpd_func = ~s | d;
            4'hC: bbpd_func = s;
            4'hD: bbpd_func = s | ~d;
            4'hE: bbpd_func = s | d;
            default: bbpd_func = BBPD_ALL_ONES;
        endcase
    endfunction

    logic [15:0] left_mask;
    logic [15:0] right_mask;
    logic [15:0] edge_mask;
    logic [15:0] raw;

    always_comb begin
        // left code n clears n bits from bit 15 downward
        left_mask = BBPD_ALL_ONES >> ctrl.left_edge_code;
        // right code n keeps n+1 bits from bit 15 downward
        right_mask = ~(BBPD_ALL_ONES >> ({1'b0, ctrl.right_edge_code} + 5'h01));
        // both edges gate together for narrow transfers
        edge_mask = line_mode ? BBPD_ALL_ONES : (left_mask & right_mask);
        raw = bbpd_func(ctrl.function_select_field, ops.src, ops.dst);
        lu_out.mask = edge_mask;
        lu_out.result = (raw & edge_mask) | (ops.dst & ~edge_mask);
    end

endmodule

/* verilog/bbpd_top.sv */
// Functional notes
// - control word: function, shift, left, right codes
// - load strobe captures data pins into control
// - line mode uses function field only
// - function codes 0-7 per-bit table
// - function codes 8-15 per-bit table
// - sixteen shift positions, zero passes A
// - low 16-i bits of A, top i of B
// - mask zero keeps destination bit
// - left and right masks apply together
// - left clears n bits, right keeps n+1
// - source and destination words pass master input latch
// - source path latches, shifter, FIFO; destination direct
// - second operand FIFO or pixel latch by mode
// - data pins carry result or FIFO head
// - release data pins when not outputting
// - pixel pin carries selected result bit
// - pixel select zero is bit 0, 0Fh bit 15
`timescale 1ns/10ps
module bbpd_top
    import bbpd_pkg::*;
#(
    parameter int FIFO_DEPTH = BBPD_FIFO_DEPTH
)(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_b,
    input wire logic control_load_strobe,
    input wire logic source_strobe,
    input wire logic dest_strobe,
    input wire logic line_mode,
    input wire logic barrel_swap,
    input wire logic fifo_write,
    input wire logic fifo_in_select,
    input wire logic fifo_read,
    input wire logic data_drive,
    input wire logic out_select,
    input wire logic pixel_in,
    input wire logic pixel_load,
    input wire logic pixel_drive,
    input wire logic [3:0] pixel_bit_select,
    output logic pixel_out,
    output logic pixel_oe_b,
    output logic fifo_full,
    output logic fifo_empty
);

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

    // ------------------------------------------------------------
    // barrel shift: {a,b} shifted left by i, upper half kept
    // ------------------------------------------------------------
    function automatic logic [15:0] bbpd_shift(input logic [15:0] a, input logic [15:0] b,
                                               input logic [3:0] i);
        logic [31:0] joined;
        joined = {a, b} << i;
        bbpd_shift = joined[31:16];
    endfunction

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    bbpd_ctrl_t ctrl_reg;
    bbpd_ctrl_t ctrl_next;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (control_load_strobe) begin
            ctrl_next = bbpd_ctrl_t'(data_in);
        end
    end

    // no documented reset; cleared so simulation starts defined
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= bbpd_ctrl_t'(BBPD_CTRL_RESET);
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ------------------------------------------------------------
    // input latches
    // ------------------------------------------------------------
    logic [15:0] master_reg, master_next;
    logic src_pend_reg, src_pend_next;
    logic dst_pend_reg, dst_pend_next;
    logic [15:0] src_latch_reg, src_latch_next;
    logic [15:0] pipe_reg, pipe_next;
    logic [15:0] dst_latch_reg, dst_latch_next;
    logic pixel_reg, pixel_next;

    always_comb begin
        master_next = data_in;
        src_pend_next = source_strobe;
        dst_pend_next = dest_strobe;
        src_latch_next = src_pend_reg ? master_reg : src_latch_reg;
        // pipeline latch takes the source latch's previous word on each source load
        pipe_next = src_pend_reg ? src_latch_reg : pipe_reg;
        dst_latch_next = dst_pend_reg ? master_reg : dst_latch_reg;
        pixel_next = pixel_load ? pixel_in : pixel_reg;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            master_reg <= BBPD_WORD_RESET;
            src_pend_reg <= 1'b0;
            dst_pend_reg <= 1'b0;
            src_latch_reg <= BBPD_WORD_RESET;
            pipe_reg <= BBPD_WORD_RESET;
            dst_latch_reg <= BBPD_WORD_RESET;
            pixel_reg <= 1'b0;
        end else begin
            master_reg <= master_next;
            src_pend_reg <= src_pend_next;
            dst_pend_reg <= dst_pend_next;
            src_latch_reg <= src_latch_next;
            pipe_reg <= pipe_next;
            dst_latch_reg <= dst_latch_next;
            pixel_reg <= pixel_next;
        end
    end

    // ------------------------------------------------------------
    // barrel shifter and logic unit
    // ------------------------------------------------------------
    logic [15:0] shift_a, shift_b, shift_out;
    logic [15:0] fifo_head;
    bbpd_operands_t ops;
    bbpd_lu_out_t lu_out;

    always_comb begin
        // word swap lets rectangles be fetched right to left
        shift_a = barrel_swap ? src_latch_reg : pipe_reg;
        shift_b = barrel_swap ? pipe_reg : src_latch_reg;
        shift_out = bbpd_shift(shift_a, shift_b, ctrl_reg.shift_count_field);
        ops.dst = dst_latch_reg;
        ops.src = line_mode ? {16{pixel_reg}} : fifo_head;
    end

    bbpd_logic_unit u_logic (
        .ctrl(ctrl_reg),
        .line_mode(line_mode),
        .ops(ops),
        .lu_out(lu_out)
    );

    // ------------------------------------------------------------
    // FIFO
    // ------------------------------------------------------------
    logic [15:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic do_write, do_read;
    logic [15:0] fifo_wdata;

    // write when full and read when empty are dropped silently
    always_comb begin
        do_write = fifo_write && (count_reg != CNT_FULL);
        do_read = fifo_read && (count_reg != '0);
        fifo_wdata = (fifo_in_select == BBPD_FIFO_IN_RESULT) ? lu_out.result : shift_out;
        wr_ptr_next = do_write ? PTR_W'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = do_read ? PTR_W'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        count_next = count_reg;
        if (do_write && !do_read) begin
            count_next = CNT_W'(count_reg + 1'b1);
        end else if (do_read && !do_write) begin
            count_next = CNT_W'(count_reg - 1'b1);
        end
        // empty head reads zero so no unwritten word reaches the logic unit
        fifo_head = (count_reg == '0) ? BBPD_WORD_RESET : fifo_mem[rd_ptr_reg];
    end

    always_ff @(posedge clock) begin
        if (do_write) begin
            fifo_mem[wr_ptr_reg] <= fifo_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic [15:0] data_out_reg, data_out_next;
    logic data_oe_b_reg, data_oe_b_next;
    logic pixel_out_reg, pixel_out_next;
    logic pixel_oe_b_reg, pixel_oe_b_next;
    logic fifo_full_reg, fifo_full_next;
    logic fifo_empty_reg, fifo_empty_next;

    always_comb begin
        data_out_next = (out_select == BBPD_OUT_FIFO) ? fifo_head : lu_out.result;
        data_oe_b_next = !data_drive;
        pixel_out_next = lu_out.result[pixel_bit_select];
        pixel_oe_b_next = !pixel_drive;
        fifo_full_next = (count_next == CNT_FULL);
        fifo_empty_next = (count_next == '0);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            data_out_reg <= BBPD_WORD_RESET;
            data_oe_b_reg <= 1'b1;
            pixel_out_reg <= 1'b0;
            pixel_oe_b_reg <= 1'b1;
            fifo_full_reg <= 1'b0;
            fifo_empty_reg <= 1'b1;
        end else begin
            data_out_reg <= data_out_next;
            data_oe_b_reg <= data_oe_b_next;
            pixel_out_reg <= pixel_out_next;
            pixel_oe_b_reg <= pixel_oe_b_next;
            fifo_full_reg <= fifo_full_next;
            fifo_empty_reg <= fifo_empty_next;
        end
    end

    assign data_out = data_out_reg;
    assign data_oe_b = data_oe_b_reg;
    assign pixel_out = pixel_out_reg;
    assign pixel_oe_b = pixel_oe_b_reg;
    assign fifo_full = fifo_full_reg;
    assign fifo_empty = fifo_empty_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_ctrl_load;
        control_load_strobe |=> ctrl_reg == bbpd_ctrl_t'($past(data_in));
    endproperty
    a_ctrl_load: assert property (p_ctrl_load) else $error("control not loaded");

    property p_ctrl_hold;
        !control_load_strobe [*2] |-> $stable(ctrl_reg);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed");

    property p_src_path;
        source_strobe |=> ##1 src_latch_reg == $past(data_in, 2) &&
            pipe_reg == $past(src_latch_reg);
    endproperty
    a_src_path: assert property (p_src_path) else $error("source path order");

    property p_dst_path;
        dest_strobe |-> ##2 dst_latch_reg == $past(data_in, 2);
    endproperty
    a_dst_path: assert property (p_dst_path) else $error("destination latch");

    property p_shift_zero;
        ctrl_reg.shift_count_field == 4'h0 && !barrel_swap |-> shift_out == pipe_reg;
    endproperty
    a_shift_zero: assert property (p_shift_zero) else $error("zero shift");

    property p_mask_keep;
        !line_mode |-> ((lu_out.result ^ dst_latch_reg) & ~lu_out.mask) == 16'h0000;
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("masked bit changed");

    property p_line_ones;
        line_mode && ctrl_reg.function_select_field == 4'hF |-> lu_out.result == 16'hFFFF;
    endproperty
    a_line_ones: assert property (p_line_ones) else $error("line mode masked");

    property p_release;
        !data_drive |=> data_oe_b;
    endproperty
    a_release: assert property (p_release) else $error("data pins driven");

    property p_fifo_out;
        out_select == BBPD_OUT_FIFO |=> data_out == $past(fifo_head);
    endproperty
    a_fifo_out: assert property (p_fifo_out) else $error("fifo word not output");

    property p_pixel_bit;
        1'b1 |=> pixel_out == $past(lu_out.result[pixel_bit_select]);
    endproperty
    a_pixel_bit: assert property (p_pixel_bit) else $error("pixel bit wrong");

    property p_line_src;
        line_mode && ctrl_reg.function_select_field == 4'hC |-> lu_out.result == {16{pixel_reg}};
    endproperty
    a_line_src: assert property (p_line_src) else $error("pixel operand");

endmodule
